// *** include/adcts_pkg.sv ***
// Shared constants, types and decode functions of the converter timing sequencer
package adcts_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_RES  = 8'h08;
   localparam logic [7:0] OFS_SYS  = 8'h0C;

   // converter_control fields
   localparam int CTRL_START   = 0;
   localparam int CTRL_RES8    = 1;
   localparam int CTRL_PCAL    = 2;
   localparam int CTRL_IMPR    = 3;
   localparam int CTRL_STS_LSB = 12;
   localparam int CTRL_BCS_LSB = 14;
   localparam logic [15:0] CTRL_RST = 16'h0004;

   // Status fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_CAL  = 1;
   localparam int STAT_DONE = 2;

   // system_config_one fields
   localparam int SYS_HALVE    = 0;
   localparam int SYS_IDIV_LSB = 8;
   localparam logic [15:0] SYS_RST = 16'h0000;

   // Timing in basic clock periods, load step in system clock periods
   localparam logic [5:0] CONV_10P  = 6'h34;
   localparam logic [5:0] CONV_8P   = 6'h2C;
   localparam logic [5:0] PCAL_SAVE = 6'h0C;
   localparam logic [2:0] LOAD_SYS  = 3'h6;
   localparam logic [13:0] CAL_MIN  = 14'h01E4;
   localparam int CAL_MAX = 11696;

   localparam logic [9:0] RES_ZERO = 10'h000;
   localparam logic [9:0] RES_FULL = 10'h3FF;

   typedef enum logic [2:0] {ST_IDLE, ST_CAL, ST_SAMPLE, ST_CONV, ST_LOAD} adcts_state_t;

   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } adcts_req_t;

   typedef struct packed {
      logic       halve;
      logic       improved;
      logic [1:0] bc_sel;
      logic [5:0] imp_div;
   } adcts_clk_cfg_t;

   function automatic logic [6:0] presc_div(input logic [1:0] sel);
      case (sel)
         2'h0:    presc_div = 7'h04;
         2'h1:    presc_div = 7'h02;
         2'h2:    presc_div = 7'h10;
         default: presc_div = 7'h08;
      endcase
   endfunction : presc_div

   function automatic logic [6:0] sample_bc(input logic [1:0] sel);
      case (sel)
         2'h0:    sample_bc = 7'h08;
         2'h1:    sample_bc = 7'h10;
         2'h2:    sample_bc = 7'h20;
         default: sample_bc = 7'h40;
      endcase
   endfunction : sample_bc

   function automatic logic [5:0] conv_bc(input logic res8, input logic pcal);
      logic [5:0] base;
      base    = res8 ? CONV_8P : CONV_10P;
      conv_bc = pcal ? base : base - PCAL_SAVE;
   endfunction : conv_bc

endpackage : adcts_pkg

// *** design/adcts_clkdiv.sv ***
// System clock enable and basic clock prescaler
`timescale 1ns/10ps
`default_nettype none
module adcts_clkdiv
(
   // Clock and reset
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   // Configuration
   input  wire adcts_pkg::adcts_clk_cfg_t cfg,
   // Enables
   output logic                           sys_en,
   output logic                           bc_en
);

   logic       ph_q;
   logic       ph_d;
   logic [6:0] cnt_q;
   logic [6:0] cnt_d;
   logic [6:0] target;

   always_comb
   begin
      ph_d   = ~ph_q;
      // System clock runs with the CPU clock: master clock or half of it
      sys_en = cfg.halve ? ph_q : 1'b1; // RULE_12 RULE_13
      if (cfg.improved)
      begin
         target = {1'b0, cfg.imp_div} + 7'h01; // RULE_11
      end
      else
      begin
         target = adcts_pkg::presc_div(cfg.bc_sel); // RULE_01
      end
      cnt_d = cnt_q;
      bc_en = 1'b0;
      if (sys_en)
      begin
         // Compare with >= so a smaller divider chosen mid-count recovers at once
         if (cnt_q >= target - 7'h01)
         begin
            cnt_d = 7'h00;
            bc_en = 1'b1;
         end
         else
         begin
            cnt_d = cnt_q + 7'h01;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_q  <= 1'b0;
         cnt_q <= 7'h00;
      end
      else
      begin
         ph_q  <= ph_d;
         cnt_q <= cnt_d;
      end
   end

endmodule : adcts_clkdiv
`default_nettype wire

// *** design/adcts_ahb_slave.sv ***
// AHB-Lite slave front end: zero-wait writes, one wait state on reads
`timescale 1ns/10ps
`default_nettype none
module adcts_ahb_slave
(
   // Clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // AHB-Lite
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic [31:0]                hrdata,
   output logic                       hresp,
   // Register side
   output adcts_pkg::adcts_req_t      req,
   output logic [7:0]                 rd_addr,
   input  wire logic [31:0]           rd_data
);

   logic        wr_q;
   logic        wr_d;
   logic        rd_q;
   logic        rd_d;
   logic        rdw_q;
   logic        rdw_d;
   logic [7:0]  addr_q;
   logic [7:0]  addr_d;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic        acc;

   always_comb
   begin
      // Only whole-word transfers are taken; other sizes pass unanswered in effect
      acc       = hsel && htrans[1] && hready && (hsize == 3'h2);
      hreadyout = !(rd_q && !rdw_q);
      addr_d    = acc ? haddr[7:0] : addr_q;
      hrdata_d  = (rd_q && !rdw_q) ? rd_data : hrdata_q;
      if (hready)
      begin
         wr_d  = acc && hwrite;
         rd_d  = acc && !hwrite;
         rdw_d = 1'b0;
      end
      else
      begin
         wr_d  = wr_q;
         rd_d  = rd_q;
         rdw_d = rd_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         rdw_q    <= 1'b0;
         addr_q   <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end
      else
      begin
         wr_q     <= wr_d;
         rd_q     <= rd_d;
         rdw_q    <= rdw_d;
         addr_q   <= addr_d;
         hrdata_q <= hrdata_d;
      end
   end

   assign hrdata    = hrdata_q;
   assign hresp     = 1'b0;
   assign req.wr    = wr_q;
   assign req.addr  = addr_q;
   assign req.wdata = hwdata;
   assign rd_addr   = addr_q;

endmodule : adcts_ahb_slave
`default_nettype wire

// *** design/adcts_top.sv ***
// Converter timing sequencer: prescaler, sample/convert/load sequencing, calibration
// Function
// RULE_01: Basic clock is system clock divided by 4, 2, 16 or 8 per select code.
// RULE_02: Sample phase lasts 8, 16, 32 or 64 basic clock periods per select code.
// RULE_03: 10-bit conversion: 52 or 40 basic periods, plus sample, plus 6 system periods.
// RULE_04: 8-bit conversion: 44 or 32 basic periods, plus sample, plus 6 system periods.
// RULE_05: Switching post-calibration off saves exactly 12 basic clock periods.
// RULE_06: Conversion is sample, result determination, then a 6 system period load.
// RULE_07: Input below ground yields zero; above reference yields 3FF.
// RULE_08: Calibration after reset lasts 484 to 11696 basic periods, noise dependent.
// RULE_09: Conversions are accepted during calibration and extend it.
// RULE_10: Software keeps the basic clock between 0.5 MHz and 20 MHz.
// RULE_11: Fixed encodings apply in compatibility mode; an improved divider is selectable.
// RULE_12: CPU clock is the master clock or half of it, one bit selects.
// RULE_13: System clock always runs at the CPU clock rate.
// RULE_14: Each conversion loads the result once and raises a visible done flag.
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module adcts_top
#(
   parameter int CAL_MAX_BC = adcts_pkg::CAL_MAX
)
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Analog front end
   input  wire logic [9:0]  ain_code,
   input  wire logic        ain_below_gnd,
   input  wire logic        ain_above_ref,
   input  wire logic        ref_quiet,
   output logic             sample_hold,
   output logic             conv_active,
   output logic             cal_run,
   output logic             conv_done
);

   adcts_pkg::adcts_req_t     req;
   adcts_pkg::adcts_clk_cfg_t clk_cfg;
   adcts_pkg::adcts_state_t   state_q;
   adcts_pkg::adcts_state_t   state_d;

   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        sys_en;
   logic        bc_en;

   logic [15:0] ctrl_q;
   logic [15:0] ctrl_d;
   logic [15:0] sys_q;
   logic [15:0] sys_d;
   logic [9:0]  res_q;
   logic [9:0]  res_d;
   logic [9:0]  smp_q;
   logic [9:0]  smp_d;
   logic        done_q;
   logic        done_d;
   logic        cal_act_q;
   logic        cal_act_d;
   logic [13:0] cal_cnt_q;
   logic [13:0] cal_cnt_d;
   logic [6:0]  cnt_q;
   logic [6:0]  cnt_d;
   logic [6:0]  samp_len_q;
   logic [6:0]  samp_len_d;
   logic [5:0]  conv_len_q;
   logic [5:0]  conv_len_d;
   logic        res8_q;
   logic        res8_d;

   logic        wr_ctrl;
   logic        wr_stat;
   logic        wr_sys;
   logic        start;
   logic        done_set;
   logic [13:0] cal_next;
   logic [6:0]  cnt_inc;

   localparam logic [13:0] CAL_LIMIT = 14'(CAL_MAX_BC);

   function automatic logic [9:0] saturate(input logic [9:0] code, input logic below,
                                           input logic above, input logic r8);
      if (below)
      begin
         saturate = adcts_pkg::RES_ZERO;
      end
      else if (above)
      begin
         saturate = adcts_pkg::RES_FULL;
      end
      else if (r8)
      begin
         saturate = {code[9:2], 2'h0};
      end
      else
      begin
         saturate = code;
      end
   endfunction : saturate

   adcts_ahb_slave u_slave
   (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .hresp     (hresp),
      .req       (req),
      .rd_addr   (rd_addr),
      .rd_data   (rd_data)
   );

   assign clk_cfg.halve    = sys_q[adcts_pkg::SYS_HALVE];
   assign clk_cfg.improved = ctrl_q[adcts_pkg::CTRL_IMPR];
   assign clk_cfg.bc_sel   = ctrl_q[adcts_pkg::CTRL_BCS_LSB +: 2];
   assign clk_cfg.imp_div  = sys_q[adcts_pkg::SYS_IDIV_LSB +: 6];

   adcts_clkdiv u_clkdiv
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cfg     (clk_cfg),
      .sys_en  (sys_en),
      .bc_en   (bc_en)
   );

   // Register access decode and read mux
   always_comb
   begin
      wr_ctrl = 1'b0;
      wr_stat = 1'b0;
      wr_sys  = 1'b0;
      if (req.wr && req.addr == adcts_pkg::OFS_CTRL)
      begin
         wr_ctrl = 1'b1;
      end
      else if (req.wr && req.addr == adcts_pkg::OFS_STAT)
      begin
         wr_stat = 1'b1;
      end
      else if (req.wr && req.addr == adcts_pkg::OFS_SYS)
      begin
         wr_sys = 1'b1;
      end
      rd_data = 32'h0000_0000;
      if (rd_addr == adcts_pkg::OFS_CTRL)
      begin
         rd_data = {16'h0000, ctrl_q};
      end
      else if (rd_addr == adcts_pkg::OFS_STAT)
      begin
         rd_data[adcts_pkg::STAT_BUSY] = (state_q != adcts_pkg::ST_IDLE)
                                         && (state_q != adcts_pkg::ST_CAL);
         rd_data[adcts_pkg::STAT_CAL]  = cal_act_q;
         rd_data[adcts_pkg::STAT_DONE] = done_q;
      end
      else if (rd_addr == adcts_pkg::OFS_RES)
      begin
         rd_data = {22'h00_0000, res_q};
      end
      else if (rd_addr == adcts_pkg::OFS_SYS)
      begin
         rd_data = {16'h0000, sys_q};
      end
   end

   // Configuration registers; the start bit is a strobe and reads back as zero
   always_comb
   begin
      ctrl_d = ctrl_q;
      sys_d  = sys_q;
      if (wr_ctrl)
      begin
         ctrl_d = req.wdata[15:0];
         ctrl_d[adcts_pkg::CTRL_START] = 1'b0;
      end
      if (wr_sys)
      begin
         sys_d = req.wdata[15:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_q <= adcts_pkg::CTRL_RST;
         sys_q  <= adcts_pkg::SYS_RST;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         sys_q  <= sys_d;
      end
   end

   // Sequencer
   always_comb
   begin
      // A start during a running conversion is dropped, not queued
      start      = wr_ctrl && req.wdata[adcts_pkg::CTRL_START]
                   && (state_q == adcts_pkg::ST_IDLE || state_q == adcts_pkg::ST_CAL);
      state_d    = state_q;
      cnt_d      = cnt_q;
      cnt_inc    = cnt_q + 7'h01;
      cal_next   = cal_cnt_q + 14'h0001;
      cal_cnt_d  = cal_cnt_q;
      cal_act_d  = cal_act_q;
      samp_len_d = samp_len_q;
      conv_len_d = conv_len_q;
      res8_d     = res8_q;
      smp_d      = smp_q;
      res_d      = res_q;
      done_set   = 1'b0;
      case (state_q)
         adcts_pkg::ST_IDLE, adcts_pkg::ST_CAL:
         begin
            if (start)
            begin
               // Calibration count is frozen while a conversion runs
               state_d    = adcts_pkg::ST_SAMPLE; // RULE_09
               cnt_d      = 7'h00;
               // Fields come from the starting write itself; the register lags one cycle
               samp_len_d = adcts_pkg::sample_bc(
                               req.wdata[adcts_pkg::CTRL_STS_LSB +: 2]); // RULE_02
               conv_len_d = adcts_pkg::conv_bc(req.wdata[adcts_pkg::CTRL_RES8], // RULE_03 RULE_04
                                               req.wdata[adcts_pkg::CTRL_PCAL]); // RULE_05
               res8_d     = req.wdata[adcts_pkg::CTRL_RES8];
            end
            else if (state_q == adcts_pkg::ST_CAL && bc_en)
            begin
               cal_cnt_d = cal_next;
               if ((cal_next >= adcts_pkg::CAL_MIN && ref_quiet) || cal_next >= CAL_LIMIT)
               begin
                  state_d   = adcts_pkg::ST_IDLE; // RULE_08
                  cal_act_d = 1'b0;
               end
            end
         end
         adcts_pkg::ST_SAMPLE:
         begin
            if (bc_en)
            begin
               cnt_d = cnt_inc;
               if (cnt_inc == samp_len_q)
               begin
                  state_d = adcts_pkg::ST_CONV; // RULE_06
                  cnt_d   = 7'h00;
                  smp_d   = saturate(ain_code, ain_below_gnd, ain_above_ref, res8_q); // RULE_07
               end
            end
         end
         adcts_pkg::ST_CONV:
         begin
            if (bc_en)
            begin
               cnt_d = cnt_inc;
               if (cnt_inc == {1'b0, conv_len_q})
               begin
                  state_d = adcts_pkg::ST_LOAD; // RULE_03 RULE_04
                  cnt_d   = 7'h00;
               end
            end
         end
         adcts_pkg::ST_LOAD:
         begin
            if (sys_en)
            begin
               cnt_d = cnt_inc;
               if (cnt_inc == {4'h0, adcts_pkg::LOAD_SYS})
               begin
                  res_d    = smp_q; // RULE_06 RULE_14
                  done_set = 1'b1;
                  cnt_d    = 7'h00;
                  state_d  = cal_act_q ? adcts_pkg::ST_CAL : adcts_pkg::ST_IDLE; // RULE_09
               end
            end
         end
         default:
         begin
            state_d = adcts_pkg::ST_IDLE;
         end
      endcase
      // Set wins over a software clear in the same cycle
      done_d = done_set || (done_q && !(wr_stat && req.wdata[adcts_pkg::STAT_DONE])); // RULE_14
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q    <= adcts_pkg::ST_CAL;
         cal_act_q  <= 1'b1;
         cal_cnt_q  <= 14'h0000;
         cnt_q      <= 7'h00;
         samp_len_q <= 7'h00;
         conv_len_q <= 6'h00;
         res8_q     <= 1'b0;
         smp_q      <= 10'h000;
         res_q      <= 10'h000;
         done_q     <= 1'b0;
      end
      else
      begin
         state_q    <= state_d;
         cal_act_q  <= cal_act_d;
         cal_cnt_q  <= cal_cnt_d;
         cnt_q      <= cnt_d;
         samp_len_q <= samp_len_d;
         conv_len_q <= conv_len_d;
         res8_q     <= res8_d;
         smp_q      <= smp_d;
         res_q      <= res_d;
         done_q     <= done_d;
      end
   end

   assign sample_hold = (state_q == adcts_pkg::ST_SAMPLE);
   assign conv_active = (state_q == adcts_pkg::ST_CONV) || (state_q == adcts_pkg::ST_LOAD);
   assign cal_run     = cal_act_q;
   assign conv_done   = done_q;

endmodule : adcts_top
`default_nettype wire

// *** sim/adcts_checker.sv ***
// Concurrent checks on the converter timing sequencer ports
`timescale 1ns/10ps
`default_nettype none
module adcts_checker
#(
   parameter int CAL_MAX_BC = 11696
)
(
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // AHB-Lite
   input  wire logic       hsel,
   input  wire logic [1:0] htrans,
   input  wire logic       hwrite,
   input  wire logic [2:0] hsize,
   input  wire logic       hready,
   input  wire logic       hreadyout,
   input  wire logic       hresp,
   // Sequencer state
   input  wire logic       sample_hold,
   input  wire logic       conv_active,
   input  wire logic       cal_run,
   input  wire logic       conv_done
);
   logic [15:0] sh_d;
   logic [15:0] sh_q;
   logic [15:0] cal_d;
   logic [15:0] cal_q;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Saturating, so a stuck calibration cannot wrap and look short
   always_comb
   begin
      sh_d  = sample_hold ? sh_q + 16'h0001 : 16'h0000;
      cal_d = (cal_run && cal_q != 16'hFFFF) ? cal_q + 16'h0001 : cal_q;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sh_q  <= 16'h0000;
         cal_q <= 16'h0000;
      end
      else
      begin
         sh_q  <= sh_d;
         cal_q <= cal_d;
      end
   end

   sequence s_rd_take;
      hsel && htrans[1] && hready && !hwrite && hsize == 3'h2;
   endsequence
   sequence s_one_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   a_read_wait_one: assert property (s_rd_take |=> s_one_wait)
      else $error("read data phase not one wait state");
   a_write_no_wait: assert property
      (hsel && htrans[1] && hready && hwrite && hsize == 3'h2 |=> hreadyout)
      else $error("write data phase stalled");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   a_sample_min_len: assert property ($rose(sample_hold) |-> sample_hold[*8])
      else $error("sample phase too short");
   // Longest basic period is 64 system periods, doubled when the clock is halved
   a_sample_max_len: assert property (sh_q < 16'h2000)
      else $error("sample phase too long");
   a_phase_excl: assert property (!(sample_hold && conv_active))
      else $error("sample and conversion overlap");
   a_sample_to_conv: assert property ($fell(sample_hold) |-> conv_active)
      else $error("conversion did not follow sample");
   a_conv_min_len: assert property ($rose(conv_active) |-> conv_active[*8])
      else $error("conversion phase too short");
   a_conv_sets_done: assert property ($fell(conv_active) |-> ##[0:2] conv_done)
      else $error("done not raised after conversion");
   a_done_at_end: assert property ($rose(conv_done) |-> !sample_hold)
      else $error("done raised during sample");
   a_cal_runs_once: assert property (!cal_run |=> !cal_run)
      else $error("calibration restarted without reset");
   a_cal_min_len: assert property ($fell(cal_run) |-> cal_q >= 16'h03C8)
      else $error("calibration shorter than minimum");
endmodule : adcts_checker

bind adcts_top adcts_checker #(.CAL_MAX_BC(CAL_MAX_BC)) u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .sample_hold(sample_hold),
   .conv_active(conv_active), .cal_run(cal_run), .conv_done(conv_done));
`default_nettype wire

// *** sim/adcts_afe_model.sv ***
// Analog front end model: input code, range flags and reference noise flag
`timescale 1ns/10ps
`default_nettype none
module adcts_afe_model
(
   // Clock
   input  wire logic       hclk,
   // Converter side
   input  wire logic       sample_hold,
   output logic [9:0]      ain_code,
   output logic            ain_below_gnd,
   output logic            ain_above_ref,
   output logic            ref_quiet,
   // Bench control
   input  wire logic [1:0] mode,
   input  wire logic [9:0] code
);
   logic [9:0] junk_q = 10'h2AA;

   // Off the sample window the code moves each cycle, so early or late capture shows
   always_ff @(posedge hclk)
      junk_q <= ~junk_q;

   assign ain_code      = sample_hold ? code : junk_q;
   assign ain_below_gnd = mode[0];
   assign ain_above_ref = mode[1];
   // Quiet reference lets calibration end at its shortest
   assign ref_quiet     = 1'b1;
endmodule : adcts_afe_model
`default_nettype wire

// *** sim/test_adc_timing_sequencer.sv ***
// Self-checking bench for the converter timing sequencer
`timescale 1ns/10ps
`default_nettype none
module test_adc_timing_sequencer;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic [9:0]  ain_code;
   logic        ain_below_gnd;
   logic        ain_above_ref;
   logic        ref_quiet;
   logic        sample_hold;
   logic        conv_active;
   logic        cal_run;
   logic        conv_done;
   logic [1:0]  md;
   logic [9:0]  code;
   logic [31:0] rd;
   int          fail_count;
   int          checks_done;
   int          cyc;
   int          rel;
   // Entries 2 to 4 keep the basic clock in band; codes 00/01 cannot at this rate
   logic [15:0] ctl [5] = '{16'h0005, 16'h5003, 16'hA001, 16'hF007, 16'h000D};
   logic [15:0] sysc [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0900};
   logic [1:0]  mdt [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};

   adcts_top #(.CAL_MAX_BC(600)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .ain_code(ain_code), .ain_below_gnd(ain_below_gnd), .ain_above_ref(ain_above_ref),
      .ref_quiet(ref_quiet), .sample_hold(sample_hold), .conv_active(conv_active),
      .cal_run(cal_run), .conv_done(conv_done));
   adcts_afe_model afe (.hclk(hclk), .sample_hold(sample_hold), .ain_code(ain_code),
      .ain_below_gnd(ain_below_gnd), .ain_above_ref(ain_above_ref),
      .ref_quiet(ref_quiet), .mode(md), .code(code));

   always @(posedge hclk)
      cyc <= cyc + 1;

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask : chk

   task automatic chk_rng(input string nm, input int lo, input int hi, input int v);
      checks_done++;
      if (v < lo || v > hi)
      begin
         $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, v);
         fail_count++;
      end
   endtask : chk_rng

   // Waits for bus ready (w=0), done high (w=1) or calibration end (w=2)
   task automatic wait_on(input int w, input int lim);
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while ((w == 0 ? hreadyout : w == 1 ? conv_done : !cal_run) !== 1'b1 && n < lim);
      if (n >= lim)
      begin
         fail_count++;
         summarize();
      end
   endtask : wait_on

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h000000, a};
      hwrite <= wr;
      wait_on(0, 64);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_on(0, 64);
      rd = hrdata;
   endtask : bus

   function automatic int per(input int i);
      int d;
      case (ctl[i][15:14])
         2'h0:    d = 4;
         2'h1:    d = 2;
         2'h2:    d = 16;
         default: d = 8;
      endcase
      if (ctl[i][3])
         d = sysc[i][13:8] + 1;
      return d * (sysc[i][0] ? 2 : 1);
   endfunction : per

   function automatic int exp_len(input int i);
      int c;
      c = (ctl[i][1] ? 44 : 52) - (ctl[i][2] ? 0 : 12);
      return ((8 << ctl[i][13:12]) + c) * per(i) + 6 * (sysc[i][0] ? 2 : 1);
   endfunction : exp_len

   task automatic convert(input int i);
      int t0;
      logic [9:0] er;
      er = mdt[i][0] ? 10'h000 : mdt[i][1] ? 10'h3FF : ctl[i][1] ? code & 10'h3FC : code;
      md <= mdt[i];
      bus(1'b1, adcts_pkg::OFS_SYS, {16'h0000, sysc[i]});
      bus(1'b1, adcts_pkg::OFS_CTRL, {16'h0000, ctl[i]});
      t0 = cyc;
      bus(1'b0, adcts_pkg::OFS_STAT, 32'h0);
      chk("status busy", 32'h1 | (i == 0 ? 32'h2 : 32'h0), rd);
      wait_on(1, 8000);
      chk_rng("conv cycles", exp_len(i) - per(i), exp_len(i) + 3, cyc - t0);
      bus(1'b0, adcts_pkg::OFS_RES, 32'h0);
      chk("result", {22'h0, er}, rd);
      bus(1'b0, adcts_pkg::OFS_CTRL, 32'h0);
      chk("ctrl", {16'h0000, ctl[i] & 16'hFFFE}, rd);
      bus(1'b0, adcts_pkg::OFS_STAT, 32'h0);
      // Only the first conversion falls inside the reset calibration
      chk("status done", 32'h4 | (i == 0 ? 32'h2 : 32'h0), rd);
      bus(1'b1, adcts_pkg::OFS_STAT, 32'h4);
      @(posedge hclk);
      chk("done cleared", 32'h0, {31'h0, conv_done});
      $display("test conversion %0d done", i);
   endtask : convert

   initial
   begin
      hclk = 1'b0;
      forever
         #2.5 hclk = ~hclk;
   end

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      md = 2'h0;
      code = 10'h2A5;
      fail_count = 0;
      checks_done = 0;
      cyc = 0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rel = cyc;
      bus(1'b0, adcts_pkg::OFS_CTRL, 32'h0);
      chk("ctrl reset", 32'h4, rd);
      bus(1'b0, adcts_pkg::OFS_SYS, 32'h0);
      chk("sys reset", 32'h0, rd);
      bus(1'b0, adcts_pkg::OFS_STAT, 32'h0);
      chk("status reset", 32'h2, rd);
      bus(1'b1, 8'h10, 32'hFFFF);
      bus(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("test reset values done");
      convert(0);
      wait_on(2, 8000);
      chk_rng("cal cycles", 2160, 2210, cyc - rel);
      $display("test calibration done");
      for (int i = 1; i < 5; i++)
         convert(i);
      summarize();
   end
endmodule : test_adc_timing_sequencer
`default_nettype wire
